// ### bpca_pkg.sv
package bpca_pkg;

  // bus clock: 100 MHz core clock divided to about 10 MHz
  localparam int unsigned CORE_PERIOD_NS = 10;
  localparam int unsigned BUS_CLK_PERIOD_NS = 100;
  localparam int unsigned BUS_CLK_HALF_CYC =
      (BUS_CLK_PERIOD_NS / 2 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_HALF_LAST = DIV_W'(BUS_CLK_HALF_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;

  // constant clock runs at the same rate as the bus clock here
  localparam logic SYNC_RESET = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_OWNER = 3'b100
  } bpca_state_type;

endpackage

// ### bpca_sync_if.sv
`timescale 1ns/10ps
interface bpca_sync_if;
  logic raw;
  logic synced;
  modport src (output raw, input synced);
  modport snk (input raw, output synced);
endinterface

// ### bpca_sync.sv
`timescale 1ns/10ps
// two flip-flop synchroniser for one pin level
module bpca_sync (
  input  wire logic   core_clk_i,
  input  wire logic   resetn_i,
  bpca_sync_if.snk    sig
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb begin
    nxt_meta = sig.raw;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_ff <= bpca_pkg::SYNC_RESET;
      sync_ff <= bpca_pkg::SYNC_RESET;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sig.synced = sync_ff;
endmodule

// ### bpca_arbiter.sv
`timescale 1ns/10ps
// Overview of operation
// R01: the board can both acquire the shared bus and release it again.
// R02: a lone master has its priority input held low by the system, so it always holds the grant.
// R03: only one master in the system drives the bus and constant clocks; the rest leave them off.
// R04: a clock source enable lets this master stop driving both bus clocks.
// R05: in the serial chain only the top slot grounds its priority input; lower slots chain.
// R06: a master that holds priority and wants the bus drives its priority output high.
// R07: a master finished with the bus drives its priority output low to pass the chance down.
// R08: a master given priority that does not want the bus drives its priority output low.
// R09: the serial chain holds no more than three masters.
// R10: in parallel mode external logic grants one of up to sixteen masters via priority input.
// R11: the external encoder ranks input 7 highest and input 0 lowest.
// R12: in parallel mode every master disables its priority output; here a jumper input does it.
// R13: bus commands start only while priority input is asserted and stay until release.
module bpca_arbiter (
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  input  wire logic priority_in_n_i,
  input  wire logic bus_req_i,
  input  wire logic bus_done_i,
  input  wire logic prio_out_en_i,
  input  wire logic clk_src_en_i,
  output logic      priority_out_n_o,
  output logic      priority_out_n_oe_o,
  output logic      bus_clk_n_o,
  output logic      bus_clk_n_oe_o,
  output logic      constant_clock_n_o,
  output logic      constant_clock_n_oe_o,
  output logic      bus_owned_o,
  output logic      cmd_enable_o
);

  bpca_sync_if prio_sig ();
  bpca_sync_if oe_sig ();
  bpca_sync_if clk_sig ();

  assign prio_sig.raw = priority_in_n_i;
  assign oe_sig.raw   = prio_out_en_i;
  assign clk_sig.raw  = clk_src_en_i;

  bpca_sync u_sync_prio (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .sig        (prio_sig.snk)
  );
  bpca_sync u_sync_oe (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .sig        (oe_sig.snk)
  );
  bpca_sync u_sync_clk (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .sig        (clk_sig.snk)
  );

  logic prio_granted;
  assign prio_granted = !prio_sig.synced;

  bpca_pkg::bpca_state_type state_ff;
  bpca_pkg::bpca_state_type nxt_state;
  logic                     prio_hi_ff;
  logic                     nxt_prio_hi;
  logic                     prio_oe_ff;
  logic                     nxt_prio_oe;
  logic                     owned_ff;
  logic                     nxt_owned;
  logic                     cmd_en_ff;
  logic                     nxt_cmd_en;

  // acquire / hold / release sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bpca_pkg::ST_IDLE: begin
        if (bus_req_i) begin
          nxt_state = bpca_pkg::ST_WAIT;
        end
      end
      bpca_pkg::ST_WAIT: begin
        if (!bus_req_i) begin
          nxt_state = bpca_pkg::ST_IDLE;
        end else if (prio_granted) begin
          nxt_state = bpca_pkg::ST_OWNER; // R13
        end
      end
      bpca_pkg::ST_OWNER: begin
        if (bus_done_i) begin
          nxt_state = bpca_pkg::ST_IDLE; // R01
        end
      end
      default: begin
        nxt_state = bpca_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= bpca_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ownership and command enable follow the next state
  always_comb begin
    nxt_owned  = (nxt_state == bpca_pkg::ST_OWNER); // R13
    nxt_cmd_en = (nxt_state == bpca_pkg::ST_OWNER); // R13
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      owned_ff  <= 1'b0;
      cmd_en_ff <= 1'b0;
    end else begin
      owned_ff  <= nxt_owned;
      cmd_en_ff <= nxt_cmd_en;
    end
  end

  // high while wanting the bus with priority or owning it, low otherwise
  always_comb begin
    nxt_prio_hi = (nxt_state == bpca_pkg::ST_OWNER) ||
                  ((nxt_state == bpca_pkg::ST_WAIT) && prio_granted); // R06 R07 R08
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prio_hi_ff <= 1'b0;
    end else begin
      prio_hi_ff <= nxt_prio_hi;
    end
  end

  // jumper out turns the priority output off
  always_comb begin
    nxt_prio_oe = oe_sig.synced; // R12
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prio_oe_ff <= 1'b0;
    end else begin
      prio_oe_ff <= nxt_prio_oe;
    end
  end

  // bus and constant clock source
  logic [bpca_pkg::DIV_W-1:0] div_ff;
  logic [bpca_pkg::DIV_W-1:0] nxt_div;
  logic                       bclk_ff;
  logic                       nxt_bclk;
  logic                       clk_oe_ff;
  logic                       nxt_clk_oe;
  logic                       constant_clock_n_ff;
  logic                       nxt_constant_clock_n;
  logic                       constant_clock_n_oe_ff;
  logic                       nxt_constant_clock_n_oe;

  always_comb begin
    nxt_div  = div_ff + 4'h1;
    nxt_bclk = bclk_ff;
    if (div_ff == bpca_pkg::DIV_HALF_LAST) begin
      nxt_div  = bpca_pkg::DIV_RESET;
      nxt_bclk = !bclk_ff;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_ff  <= bpca_pkg::DIV_RESET;
      bclk_ff <= 1'b1;
    end else begin
      div_ff  <= nxt_div;
      bclk_ff <= nxt_bclk;
    end
  end

  // bus clock drive enable
  always_comb begin
    nxt_clk_oe = clk_sig.synced; // R04
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_oe_ff <= 1'b0;
    end else begin
      clk_oe_ff <= nxt_clk_oe;
    end
  end

  // constant clock runs in step with the bus clock
  always_comb begin
    nxt_constant_clock_n = nxt_bclk;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      constant_clock_n_ff <= 1'b1;
    end else begin
      constant_clock_n_ff <= nxt_constant_clock_n;
    end
  end

  // constant clock drive enable, same jumper as the bus clock
  always_comb begin
    nxt_constant_clock_n_oe = clk_sig.synced; // R04
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      constant_clock_n_oe_ff <= 1'b0;
    end else begin
      constant_clock_n_oe_ff <= nxt_constant_clock_n_oe;
    end
  end

  assign priority_out_n_o      = prio_hi_ff;
  assign priority_out_n_oe_o   = prio_oe_ff;
  assign bus_clk_n_o           = bclk_ff;
  assign bus_clk_n_oe_o        = clk_oe_ff;
  assign constant_clock_n_o    = constant_clock_n_ff;
  assign constant_clock_n_oe_o = constant_clock_n_oe_ff;
  assign bus_owned_o           = owned_ff;
  assign cmd_enable_o          = cmd_en_ff;

endmodule

// ### bpca_arbiter_props.sv
`timescale 1ns/10ps
module bpca_arbiter_props (
  input logic core_clk_i,
  input logic resetn_i,
  input logic priority_in_n_i,
  input logic bus_req_i,
  input logic bus_done_i,
  input logic prio_out_en_i,
  input logic clk_src_en_i,
  input logic priority_out_n_o,
  input logic priority_out_n_oe_o,
  input logic bus_clk_n_oe_o,
  input logic bus_clk_n_o,
  input logic constant_clock_n_o,
  input logic constant_clock_n_oe_o,
  input logic bus_owned_o,
  input logic cmd_enable_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_rel;
    bus_owned_o && bus_done_i;
  endsequence
  sequence s_half;
    $stable(bus_clk_n_o) [*4] ##1 $changed(bus_clk_n_o);
  endsequence
  a_bclk_half: assert property ($changed(bus_clk_n_o) |=> s_half)
    else $error("bus clock half period");
  a_constant_clock_n_same: assert property (constant_clock_n_o == bus_clk_n_o && constant_clock_n_oe_o == bus_clk_n_oe_o)
    else $error("constant clock");
  a_cmd_own: assert property (cmd_enable_o == bus_owned_o)
    else $error("cmd enable");
  a_grant_first: assert property ($rose(bus_owned_o) |-> !$past(priority_in_n_i, 3))
    else $error("no grant");
  a_owner_inhibit: assert property (bus_owned_o |-> priority_out_n_o)
    else $error("no inhibit");
  a_done_release: assert property (s_rel |=> !bus_owned_o && !priority_out_n_o)
    else $error("no release");
  a_idle_pass: assert property (!bus_req_i && !bus_owned_o |=> !priority_out_n_o)
    else $error("no pass");
  a_jumper_off: assert property (!prio_out_en_i [*4] |-> !priority_out_n_oe_o)
    else $error("oe in parallel");
  a_clk_src: assert property (clk_src_en_i [*4] |-> bus_clk_n_oe_o)
    else $error("clk oe");
endmodule
bind bpca_arbiter bpca_arbiter_props u_bpca_arbiter_props (.*);

// ### bpca_upstream.sv
`timescale 1ns/10ps
// higher master in the chain, answering on the (lag_i + 1)th clock after want_i differs from its output
module bpca_upstream (
  input  logic       clk_i,
  input  logic       want_i,
  input  logic [1:0] lag_i,
  output logic       prio_n_o = 1'b1
);
  logic [1:0] cnt_ff = 2'h0;
  always @(posedge clk_i) begin
    if (prio_n_o == want_i) cnt_ff <= 2'h0;
    else if (cnt_ff == lag_i) prio_n_o <= want_i;
    else cnt_ff <= cnt_ff + 2'h1;
  end
endmodule

// ### bus_priority_chain_arbiter_test.sv
`timescale 1ns/10ps
module bus_priority_chain_arbiter_test;
  logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, done = 1'b0, pen = 1'b1, cen = 1'b1, up = 1'b0;
  logic pin_n, po_n, po_oe, bc_oe, cc_oe, own, cmd, bc, cc, b;
  logic [1:0] lag = 2'h0;
  int n_mismatch = 0, n_compared = 0, seed = 62309, k, w, e;
  always #5 clk = ~clk;
  bpca_upstream u_bpca_upstream (.clk_i(clk), .want_i(up), .lag_i(lag), .prio_n_o(pin_n));
  bpca_arbiter u_bpca_arbiter (.core_clk_i(clk), .resetn_i(rst_n), .priority_in_n_i(pin_n),
    .bus_req_i(req), .bus_done_i(done), .prio_out_en_i(pen), .clk_src_en_i(cen),
    .priority_out_n_o(po_n), .priority_out_n_oe_o(po_oe), .bus_clk_n_o(bc),
    .bus_clk_n_oe_o(bc_oe), .constant_clock_n_o(cc), .constant_clock_n_oe_o(cc_oe),
    .bus_owned_o(own), .cmd_enable_o(cmd));
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    step(20);
    rst_n = 1'b1;
    check({po_n, own, cmd}, 3'h0);
    b = bc;
    for (w = 0; w < 12 && bc === b; w++) step(1);
    b = bc;
    for (w = 0; w < 12 && bc === b; w++) step(1);
    check(3'(w), 3'(bpca_pkg::BUS_CLK_HALF_CYC));
    check({2'h0, cc}, {2'h0, bc});
    for (k = 0; k < 8; k++) begin
      lag = 2'($random(seed));
      pen = 1'($random(seed));
      cen = 1'($random(seed));
      up = k[0];
      e = !k[0];
      step(8);
      req = 1'b1;
      for (w = 0; w < 12 && own !== 1'b1; w++) step(1);
      if (e == 1 && w == 12) begin
        n_mismatch++;
        break;
      end
      check({po_n, own, cmd}, {3{e[0]}});
      check({po_oe, bc_oe, cc_oe}, {pen, cen, cen});
      up = 1'b1;
      step(6);
      check({po_n, own, cmd}, {3{e[0]}});
      done = 1'b1;
      step(1);
      done = 1'b0;
      req = 1'b0;
      up = 1'b0;
      check({po_n, own, cmd}, 3'h0);
      step(8);
      check({po_n, own, cmd}, 3'h0);
    end
    give_verdict;
  end
endmodule
